// ### verilog/sfcc_status_flags.sv
// upper status byte, flag clear registers and interrupt request
`timescale 1ns/1ps
`default_nettype none
`include "sfcc_params.svh"
module sfcc_status_flags #(
  parameter int unsigned DEBOUNCE_CYCLES = `SFCC_DEBOUNCE_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire sfcc_pkg::sfcc_events_t events,
  input wire logic supply_ok_raw,
  input wire logic adapter_sense_input,
  input wire sfcc_pkg::sfcc_access_t acc,
  input wire logic [7:0] status_low_flags,
  input wire logic rd_done,
  output logic [7:0] rdata,
  output logic [7:0] clear_low_pulse,
  output logic status_low_read_clear,
  output logic auto_clear_on_read,
  output logic [7:0] int_enable,
  output logic int_n
);

  logic sense_pin_level;
  logic brownout_flag, overpower_flag, clamp_overvoltage_flag;
  logic sense_edge_flag;
  logic ok_s1_r, ok_s2_r, ok_s1_nxt, ok_s2_nxt;
  logic [2:0] ev_s1_r, ev_s2_r, ev_s1_nxt, ev_s2_nxt;
  logic [7:0] sys_ctrl_r, sys_ctrl_nxt;
  logic [7:0] int_en_r, int_en_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [7:0] clr_low_r, clr_low_nxt;
  logic [1:0] pend_rd_r, pend_rd_nxt;
  logic [7:0] clr_high;
  logic rd_high_clear;
  logic [7:0] status_high;
  logic [7:0] ie_low_mask;

  assign ie_low_mask = `SFCC_IE_LOW_MASK;

  function automatic logic is_wr(input sfcc_pkg::sfcc_access_t a,
                                 input logic [7:0] addr);
    is_wr = a.wr && (a.addr == addr);
  endfunction

  function automatic logic is_rd(input sfcc_pkg::sfcc_access_t a,
                                 input logic [7:0] addr);
    is_rd = a.rd && (a.addr == addr);
  endfunction

  // analogue comparator outputs are asynchronous to this clock
  always_comb begin
    ok_s1_nxt = supply_ok_raw;
    ok_s2_nxt = ok_s1_r;
    ev_s1_nxt = {events.brownout, events.overpower, events.clamp};
    ev_s2_nxt = ev_s1_r;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ok_s1_r <= 1'b0;
      ok_s2_r <= 1'b0;
      ev_s1_r <= 3'h0;
      ev_s2_r <= 3'h0;
    end else begin
      ok_s1_r <= ok_s1_nxt;
      ok_s2_r <= ok_s2_nxt;
      ev_s1_r <= ev_s1_nxt;
      ev_s2_r <= ev_s2_nxt;
    end
  end

  sfcc_debounce #(
    .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
  ) u_debounce (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .raw_in(adapter_sense_input),
    .level(sense_pin_level)
  );

  // clear strobes: write-one pulses, ored with the clear-on-read strobe
  always_comb begin
    clr_high = 8'h00;
    if (is_wr(acc, `SFCC_ADDR_CLEAR_HIGH)) begin
      clr_high = acc.wdata;
    end
    clr_high = clr_high | {8{rd_high_clear}};
  end

  sfcc_edge_latch u_brownout (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .event_in(ev_s2_r[2]),
    .both_edges(1'b0),
    .clear(clr_high[`SFCC_BIT_BROWNOUT]),
    .flag(brownout_flag)
  );

  sfcc_edge_latch u_overpower (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .event_in(ev_s2_r[1]),
    .both_edges(1'b0),
    .clear(clr_high[`SFCC_BIT_OVERPOWER]),
    .flag(overpower_flag)
  );

  sfcc_edge_latch u_clamp (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .event_in(ev_s2_r[0]),
    .both_edges(1'b0),
    .clear(clr_high[`SFCC_BIT_CLAMP]),
    .flag(clamp_overvoltage_flag)
  );

  // hidden latch: both edges of the debounced level, never readable, seen only through int_n
  sfcc_edge_latch u_sense_edge (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .event_in(sense_pin_level),
    .both_edges(1'b1),
    .clear(clr_high[`SFCC_BIT_SENSE]),
    .flag(sense_edge_flag)
  );

  always_comb begin
    status_high = `SFCC_STATUS_HIGH_RESET;
    status_high[`SFCC_BIT_SENSE] = sense_pin_level;
    status_high[`SFCC_BIT_BROWNOUT] = brownout_flag;
    status_high[`SFCC_BIT_OVERPOWER] = overpower_flag;
    status_high[`SFCC_BIT_CLAMP] = clamp_overvoltage_flag;
  end

  // register writes, read data and deferred clear-on-read
  always_comb begin
    sys_ctrl_nxt = sys_ctrl_r;
    int_en_nxt = int_en_r;
    rdata_nxt = rdata_r;
    clr_low_nxt = 8'h00;
    pend_rd_nxt = pend_rd_r;
    if (is_wr(acc, `SFCC_ADDR_SYS_CTRL_LOW)) begin
      sys_ctrl_nxt = acc.wdata;
    end
    if (is_wr(acc, `SFCC_ADDR_INT_ENABLE)) begin
      int_en_nxt = acc.wdata;
    end
    if (is_wr(acc, `SFCC_ADDR_CLEAR_LOW)) begin
      // bit 0 has no flag behind it: supply-ok cannot be cleared
      clr_low_nxt = {acc.wdata[7:1], 1'b0};
    end
    if (acc.rd) begin
      unique case (acc.addr)
        `SFCC_ADDR_STATUS_LOW: begin
          rdata_nxt = {status_low_flags[7:1], ok_s2_r};
        end
        `SFCC_ADDR_STATUS_HIGH: rdata_nxt = status_high;
        `SFCC_ADDR_INT_ENABLE: rdata_nxt = int_en_r;
        `SFCC_ADDR_SYS_CTRL_LOW: rdata_nxt = sys_ctrl_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
    // the clear waits for the read to finish so the value is not lost
    if (sys_ctrl_r[`SFCC_BIT_AUTO_CLEAR]) begin
      if (is_rd(acc, `SFCC_ADDR_STATUS_LOW)) begin
        pend_rd_nxt[0] = 1'b1;
      end
      if (is_rd(acc, `SFCC_ADDR_STATUS_HIGH)) begin
        pend_rd_nxt[1] = 1'b1;
      end
    end
    if (rd_done) begin
      pend_rd_nxt = 2'b00;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sys_ctrl_r <= `SFCC_SYS_CTRL_LOW_RESET;
      int_en_r <= `SFCC_INT_ENABLE_RESET;
      rdata_r <= 8'h00;
      clr_low_r <= `SFCC_CLEAR_RESET;
      pend_rd_r <= 2'b00;
    end else begin
      sys_ctrl_r <= sys_ctrl_nxt;
      int_en_r <= int_en_nxt;
      rdata_r <= rdata_nxt;
      clr_low_r <= clr_low_nxt;
      pend_rd_r <= pend_rd_nxt;
    end
  end

  assign rd_high_clear = rd_done & pend_rd_r[1];
  assign status_low_read_clear = rd_done & pend_rd_r[0];
  assign clear_low_pulse = clr_low_r;
  assign rdata = rdata_r;
  assign auto_clear_on_read = sys_ctrl_r[`SFCC_BIT_AUTO_CLEAR];
  assign int_enable = int_en_r;

  // supply-ok is not an input of this or-tree
  assign int_n = ~(
    (|({status_low_flags[7], status_low_flags[6], status_low_flags[5],
        status_low_flags[4] | status_low_flags[2],
        status_low_flags[3] | status_low_flags[1]}
       & (int_en_r[4:0] & ie_low_mask[4:0]))) |
    (overpower_flag & int_en_r[`SFCC_IE_BIT_OVERPOWER]) |
    (clamp_overvoltage_flag & int_en_r[`SFCC_IE_BIT_CLAMP]) |
    (sense_edge_flag & int_en_r[`SFCC_IE_BIT_SENSE]));

endmodule
`default_nettype wire

// ### shared/sfcc_params.svh
// register map, field positions, reset values and timing counts
`ifndef SFCC_PARAMS_SVH
`define SFCC_PARAMS_SVH

`define SFCC_ADDR_STATUS_LOW 8'h00
`define SFCC_ADDR_STATUS_HIGH 8'h01
`define SFCC_ADDR_CLEAR_LOW 8'h02
`define SFCC_ADDR_CLEAR_HIGH 8'h03
`define SFCC_ADDR_INT_ENABLE 8'h04
`define SFCC_ADDR_SYS_CTRL_LOW 8'h05

`define SFCC_STATUS_HIGH_RESET 8'h00
`define SFCC_CLEAR_RESET 8'h00
`define SFCC_SYS_CTRL_LOW_RESET 8'h80
`define SFCC_INT_ENABLE_RESET 8'h00

`define SFCC_BIT_SENSE 0
`define SFCC_BIT_BROWNOUT 1
`define SFCC_BIT_OVERPOWER 3
`define SFCC_BIT_CLAMP 4
`define SFCC_BIT_AUTO_CLEAR 7
`define SFCC_BIT_SUPPLY_OK 0

`define SFCC_IE_LOW_MASK 8'h1F
`define SFCC_IE_BIT_OVERPOWER 5
`define SFCC_IE_BIT_CLAMP 6
`define SFCC_IE_BIT_SENSE 7

`define SFCC_DEBOUNCE_MS 11
`define SFCC_CLK_HZ 40000000
`define SFCC_DEBOUNCE_CYCLES ((`SFCC_DEBOUNCE_MS * `SFCC_CLK_HZ) / 1000)

`endif

// ### shared/sfcc_pkg.sv
// types shared by the status flag capture and clear logic
package sfcc_pkg;

  // raw analogue event levels, asynchronous to the controller clock
  typedef struct packed {
    logic brownout;
    logic overpower;
    logic clamp;
  } sfcc_events_t;

  // one register access from the serial slave, one cycle wide
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfcc_access_t;

  typedef enum logic [1:0] {
    SFCC_DB_STABLE = 2'b00,
    SFCC_DB_COUNT = 2'b01
  } sfcc_db_state_t;

endpackage

// ### verilog/sfcc_debounce.sv
// debounce filter for the adapter sense pin
`timescale 1ns/1ps
`default_nettype none
`include "sfcc_params.svh"
module sfcc_debounce #(
  parameter int unsigned DEBOUNCE_CYCLES = `SFCC_DEBOUNCE_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic raw_in,
  output logic level
);

  logic sync1_r, sync2_r;
  logic sync1_nxt, sync2_nxt;
  logic level_r, level_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  sfcc_pkg::sfcc_db_state_t state_r, state_nxt;

  // a new level is accepted only after it held for the full window
  always_comb begin
    sync1_nxt = raw_in;
    sync2_nxt = sync1_r;
    level_nxt = level_r;
    cnt_nxt = cnt_r;
    state_nxt = state_r;
    unique case (state_r)
      sfcc_pkg::SFCC_DB_STABLE: begin
        if (sync2_r != level_r) begin
          state_nxt = sfcc_pkg::SFCC_DB_COUNT;
          cnt_nxt = 32'h0000_0001;
        end
      end
      sfcc_pkg::SFCC_DB_COUNT: begin
        if (sync2_r == level_r) begin
          state_nxt = sfcc_pkg::SFCC_DB_STABLE;
        end else if (cnt_r >= DEBOUNCE_CYCLES) begin
          level_nxt = sync2_r;
          state_nxt = sfcc_pkg::SFCC_DB_STABLE;
        end else begin
          cnt_nxt = cnt_r + 32'h0000_0001;
        end
      end
      default: state_nxt = sfcc_pkg::SFCC_DB_STABLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      level_r <= 1'b0;
      cnt_r <= 32'h0000_0000;
      state_r <= sfcc_pkg::SFCC_DB_STABLE;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      level_r <= level_nxt;
      cnt_r <= cnt_nxt;
      state_r <= state_nxt;
    end
  end

  assign level = level_r;

endmodule
`default_nettype wire

// ### verilog/sfcc_edge_latch.sv
// sticky event flag: onset edge sets, clear drops, set wins
`timescale 1ns/1ps
`default_nettype none
module sfcc_edge_latch (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic event_in,
  input wire logic both_edges,
  input wire logic clear,
  output logic flag
);

  logic prev_r, prev_nxt;
  logic flag_r, flag_nxt;
  logic hit;

  always_comb begin
    prev_nxt = event_in;
    hit = both_edges ? (event_in ^ prev_r) : (event_in & ~prev_r);
    flag_nxt = hit | (flag_r & ~clear);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prev_r <= 1'b0;
      flag_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
      flag_r <= flag_nxt;
    end
  end

  assign flag = flag_r;

endmodule
`default_nettype wire

// ### verif/sfcc_status_flags_chk.sv
// port-level assertions for the status flag block
`timescale 1ns/1ps
`default_nettype none
module sfcc_status_flags_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire sfcc_pkg::sfcc_access_t acc,
  input wire logic supply_ok_raw,
  input wire logic rd_done,
  input wire logic [7:0] rdata,
  input wire logic [7:0] clear_low_pulse,
  input wire logic status_low_read_clear,
  input wire logic auto_clear_on_read,
  input wire logic [7:0] int_enable,
  input wire logic int_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_int_masked: assert property (int_enable == 8'h00 |-> int_n)
    else $error("interrupt low with all enables off");
  a_low_rsvd_bit: assert property (!clear_low_pulse[0])
    else $error("reserved lower clear bit pulsed");
  a_low_clear_map: assert property (acc.wr && acc.addr == 8'h02 |=>
    clear_low_pulse == ($past(acc.wdata) & 8'hFE))
    else $error("lower clear pulse does not match write");
  a_clear_one_cycle: assert property (clear_low_pulse != 8'h00 |->
    $past(acc.wr && acc.addr == 8'h02))
    else $error("clear pulse without a write");
  a_clear_reads_zero: assert property (acc.rd &&
    (acc.addr == 8'h02 || acc.addr == 8'h03) |=> rdata == 8'h00)
    else $error("clear register read not zero");
  a_high_rsvd_zero: assert property (acc.rd && acc.addr == 8'h01
    |=> (rdata & 8'hE4) == 8'h00)
    else $error("reserved status bits set");
  a_supply_live: assert property (acc.rd && acc.addr == 8'h00 &&
    $past(supply_ok_raw, 2) == supply_ok_raw &&
    $past(supply_ok_raw, 3) == supply_ok_raw |=> rdata[0] == $past(supply_ok_raw))
    else $error("supply ok bit not live");
  a_auto_ctrl_wr: assert property (acc.wr && acc.addr == 8'h05 |=>
    auto_clear_on_read == $past(acc.wdata[7]))
    else $error("auto clear control not written");
  a_auto_reset_one: assert property ($rose(rst_n) |-> auto_clear_on_read)
    else $error("auto clear not one after reset");
  a_ie_write: assert property (acc.wr && acc.addr == 8'h04 |=>
    int_enable == $past(acc.wdata))
    else $error("interrupt enable not written");
  a_low_rd_clear: assert property (status_low_read_clear |-> rd_done)
    else $error("lower read clear outside read end");
  c_low_pulse: cover property (clear_low_pulse != 8'h00);
  c_int_low: cover property (!int_n);
  c_read_clear: cover property (status_low_read_clear);
endmodule
bind sfcc_status_flags sfcc_status_flags_chk u_chk (.clk_sys(clk_sys),
  .rst_n(rst_n), .acc(acc), .supply_ok_raw(supply_ok_raw), .rd_done(rd_done),
  .rdata(rdata), .clear_low_pulse(clear_low_pulse),
  .status_low_read_clear(status_low_read_clear),
  .auto_clear_on_read(auto_clear_on_read), .int_enable(int_enable),
  .int_n(int_n));
`default_nettype wire

// ### verif/sfcc_host_model.sv
// host side model: one-cycle register accesses and read segment ends
`timescale 1ns/1ps
`default_nettype none
module sfcc_host_model (
  input wire logic clk_sys,
  input wire logic [7:0] rdata,
  output var sfcc_pkg::sfcc_access_t acc,
  output var logic rd_done
);
  initial begin
    acc = '0;
    rd_done = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    acc <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk_sys);
    acc <= '0;
  endtask
  // data is taken one full cycle after the access, where it has settled
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    acc <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    acc <= '0;
    @(posedge clk_sys);
    #1 d = rdata;
  endtask
  task automatic done();
    @(posedge clk_sys);
    rd_done <= 1'b1;
    @(posedge clk_sys);
    rd_done <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### verif/testbench.sv
// register level tests of the status flag capture and clear block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys, rst_n, supply_ok_raw, sense, rd_done;
  logic int_n, auto_clr;
  logic [7:0] rdata, d;
  logic [7:0] m [3] = '{8'h02, 8'h08, 8'h10};
  sfcc_pkg::sfcc_events_t ev;
  sfcc_pkg::sfcc_access_t acc;
  int n_mismatch = 0, total_checks = 0, cycles = 0;
  sfcc_host_model host (.clk_sys(clk_sys), .rdata(rdata), .acc(acc),
    .rd_done(rd_done));
  sfcc_status_flags #(.DEBOUNCE_CYCLES(8)) uut (.clk_sys(clk_sys),
    .rst_n(rst_n), .events(ev), .supply_ok_raw(supply_ok_raw),
    .adapter_sense_input(sense), .acc(acc), .status_low_flags(8'hA4),
    .rd_done(rd_done), .rdata(rdata), .clear_low_pulse(),
    .status_low_read_clear(), .auto_clear_on_read(auto_clr),
    .int_enable(), .int_n(int_n));
  always #12.5 clk_sys = ~clk_sys;
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      results();
    end
  end
  task automatic check(input string what, input logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, exp);
    host.rd(a, d);
    check($sformatf("reg %h", a), d, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic int_chk(input logic exp);
    @(posedge clk_sys);
    #1 check("int_n", {7'h0, int_n}, {7'h0, exp});
  endtask
  initial begin
    clk_sys = 0;
    rst_n = 0;
    ev = '0;
    supply_ok_raw = 1;
    sense = 0;
    tick(10);
    rst_n <= 1;
    tick(2);
    rd_chk(8'h01, 8'h00);
    rd_chk(8'h02, 8'h00);
    rd_chk(8'h03, 8'h00);
    int_chk(1'b1);
    check("auto", {7'h0, auto_clr}, 8'h01);
    host.rd(8'h00, d);
    check("supply", {7'h0, d[0]}, 8'h01);
    supply_ok_raw <= 0;
    tick(4);
    host.rd(8'h00, d);
    check("supply", {7'h0, d[0]}, 8'h00);
    host.done();
    host.wr(8'h05, 8'h00);
    host.wr(8'h04, 8'hE0);
    for (int i = 0; i < 3; i++) begin
      ev[2-i] <= 1'b1;
      tick(6);
      ev[2-i] <= 1'b0;
      tick(4);
      rd_chk(8'h01, m[i]);
      int_chk(i == 0);
      host.done();
      rd_chk(8'h01, m[i]);
      host.wr(8'h03, 8'h00);
      rd_chk(8'h01, m[i]);
      host.wr(8'h03, m[i]);
      rd_chk(8'h01, 8'h00);
      int_chk(1'b1);
    end
    host.wr(8'h05, 8'h80);
    ev <= '{brownout: 1'b1, overpower: 1'b1, clamp: 1'b0};
    tick(6);
    ev <= '0;
    rd_chk(8'h01, 8'h0A);
    host.done();
    rd_chk(8'h01, 8'h00);
    int_chk(1'b1);
    host.wr(8'h02, 8'hFF);
    rd_chk(8'h02, 8'h00);
    sense <= 1;
    tick(4);
    sense <= 0;
    tick(20);
    rd_chk(8'h01, 8'h00);
    int_chk(1'b1);
    sense <= 1;
    tick(20);
    rd_chk(8'h01, 8'h01);
    int_chk(1'b0);
    host.wr(8'h03, 8'h01);
    int_chk(1'b1);
    rd_chk(8'h01, 8'h01);
    sense <= 0;
    tick(20);
    int_chk(1'b0);
    rd_chk(8'h01, 8'h00);
    host.done();
    int_chk(1'b1);
    results();
  end
endmodule
`default_nettype wire
